// file: rtl/epc_top.sv
// Purpose: EPROM programming interlock plus bootstrap copy-and-verify sequencer.
// Assumes: External counter is clocked by counter_step and cleared by counter_clear.
// Notes:   The EPROM array is modelled as a register array written only with ones.
//
// How it works
// - HV sensed low, program-enable low and latch low program the latched byte.
// - HV sense high disconnects both control bits from the EPROM array; here only programming is cut, and latch low still zeroes reads.
// - HV low, latch low, enable high latches address and data without programming.
// - Program-enable may only go low while the latch bit is low.
// - Erased cells read zero; programming only ORs ones into a byte.
// - Bootstrap routine lives in a separate fixed 115-byte mask ROM region; here a hardware sequencer stands in for it and no ROM is modelled.
// - Reset with timer pin at program level selects the bootstrap vector pair.
// - Sequence pulses counter clear high then low before any step pulse.
// - One step pulse after each location is loaded from the source byte.
// - Source addresses outside the user EPROM are skipped both passes.
// - After programming, light programmed, clear counter, repeat as verify pass.
// - Verified lights only when every user EPROM byte matched its source.
// - Latch high selects read; latch low latches with read disabled; reset sets it.
// - Program-enable set by reset, cleared only with latch low, set on changes.
// - HV sense bit is read-only, low when high voltage is present.
// - Control register uses three low bits; upper five read as ones.
`timescale 1ns/10ps
module epc_top
    import epc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        vpp_high,
    input  wire logic        timer_pin_program_level,
    input  wire logic [7:0]  src_data,
    output logic             counter_clear,
    output logic             counter_step,
    output logic             programmed_led,
    output logic             verified_led,
    output logic             boot_mode,
    output logic             irq
);
    import epc_pkg::*;

    logic             hv_s1_reg, hv_s2_reg, tp_s1_reg, tp_s2_reg;
    logic [7:0]       src_s1_reg, src_s2_reg;
    logic             program_latch_n_reg, program_enable_n_reg;
    logic [10:0]      eprom_adr_reg;
    logic [7:0]       eprom_dat_reg;
    // Every cell starts erased and reads zero.
    logic [7:0]       eprom_mem [MEM_DEPTH] = '{default: 8'h00};
    logic [7:0]       rd_byte;
    logic             hv_sense_n;
    logic             rst_seen_reg;
    epc_state_t       state_reg;
    logic [10:0]      src_adr_reg;
    logic             verify_pass_reg;
    logic [CNT_W-1:0] wait_reg;
    logic [INT_W-1:0] int_stat_reg, int_mask_reg, int_set;
    logic             start_reg;
    logic             apb_acc, apb_wr, apb_rd;
    logic             sw_prog_pulse, boot_prog_pulse;
    logic             in_user;

    assign hv_sense_n = ~hv_s2_reg;
    assign apb_acc    = psel && penable && pready;
    assign apb_wr     = apb_acc && pwrite;
    assign apb_rd     = apb_acc && !pwrite;
    assign in_user    = (src_adr_reg >= USER_LO) && (src_adr_reg < USER_HI);
    assign rd_byte    = eprom_mem[src_adr_reg];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hv_s1_reg  <= 1'b0;
            hv_s2_reg  <= 1'b0;
            src_s1_reg <= 8'h00;
            src_s2_reg <= 8'h00;
        end else begin
            hv_s1_reg  <= vpp_high;
            hv_s2_reg  <= hv_s1_reg;
            src_s1_reg <= src_data;
            src_s2_reg <= src_s1_reg;
        end
    end

    // The strap synchroniser stays out of reset: a strap held steady through reset is then
    // already through both flops at the first edge after release, when it is caught.
    always_ff @(posedge pclk) begin
        tp_s1_reg <= timer_pin_program_level;
        tp_s2_reg <= tp_s1_reg;
    end

    // The strap is caught once, at the first edge after release.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_seen_reg <= 1'b0;
            boot_mode    <= 1'b0;
            start_reg    <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            if (!rst_seen_reg) begin
                rst_seen_reg <= 1'b1;
                boot_mode    <= tp_s2_reg;
                start_reg    <= tp_s2_reg;
            end
        end
    end

    // Programming control bits; the sequencer leaves them alone and programs through its own pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_latch_n_reg  <= 1'b1;
            program_enable_n_reg <= 1'b1;
            eprom_adr_reg        <= 11'h000;
            eprom_dat_reg        <= 8'h00;
        end else if (apb_wr && paddr == OFF_PCR) begin
            program_latch_n_reg <= pwdata[PCR_LATCH_B];
            if (!pwdata[PCR_PGE_B] && !pwdata[PCR_LATCH_B]) begin
                program_enable_n_reg <= 1'b0;
            end else begin
                program_enable_n_reg <= 1'b1;
            end
        end else if (apb_wr && (paddr == OFF_EPROM_ADR || paddr == OFF_EPROM_DAT)) begin
            program_enable_n_reg <= 1'b1;
            if (paddr == OFF_EPROM_ADR) begin
                eprom_adr_reg <= pwdata[10:0];
            end else begin
                eprom_dat_reg <= pwdata[7:0];
            end
        end
    end

    // A software program pulse needs high voltage, both bits low, and no latch when disconnected.
    assign sw_prog_pulse   = !hv_sense_n && !program_enable_n_reg && !program_latch_n_reg;
    assign boot_prog_pulse = (state_reg == ST_PROG) && !verify_pass_reg && (wait_reg == '0) && hv_s2_reg;

    always_ff @(posedge pclk) begin
        if (sw_prog_pulse) begin
            eprom_mem[eprom_adr_reg] <= eprom_mem[eprom_adr_reg] | eprom_dat_reg;
        end else if (boot_prog_pulse) begin
            eprom_mem[src_adr_reg] <= eprom_mem[src_adr_reg] | src_s2_reg;
        end
    end

    // Sequencer standing in for the fixed-size bootstrap ROM program.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg       <= ST_IDLE;
            src_adr_reg     <= 11'h000;
            verify_pass_reg <= 1'b0;
            wait_reg        <= '0;
            counter_clear   <= 1'b0;
            counter_step    <= 1'b0;
            programmed_led  <= 1'b0;
            verified_led    <= 1'b0;
        end else begin
            counter_step <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start_reg || (apb_wr && paddr == OFF_BOOT_CTRL && pwdata[0])) begin
                        state_reg     <= ST_CLRH;
                        counter_clear <= 1'b1;
                    end
                end
                ST_CLRH: begin
                    counter_clear <= 1'b0;
                    src_adr_reg   <= 11'h000;
                    wait_reg      <= CNT_W'(PROG_CYC);
                    state_reg     <= ST_CLRL;
                end
                ST_CLRL: begin
                    state_reg <= ST_FETCH;
                end
                ST_FETCH: begin
                    if (!in_user) begin
                        state_reg    <= ST_STEP;
                        counter_step <= 1'b1;
                    end else if (wait_reg != '0) begin
                        wait_reg <= wait_reg - 1'b1;
                    end else begin
                        state_reg <= ST_PROG;
                    end
                end
                ST_PROG: begin
                    if (verify_pass_reg && rd_byte != src_s2_reg) begin
                        state_reg <= ST_FAIL;
                    end else begin
                        state_reg    <= ST_STEP;
                        counter_step <= 1'b1;
                    end
                end
                ST_STEP: begin
                    wait_reg <= CNT_W'(PROG_CYC);
                    if (src_adr_reg == SRC_LAST) begin
                        if (!verify_pass_reg) begin
                            programmed_led  <= 1'b1;
                            verify_pass_reg <= 1'b1;
                            counter_clear   <= 1'b1;
                            state_reg       <= ST_CLRH;
                        end else begin
                            verified_led <= 1'b1;
                            state_reg    <= ST_DONE;
                        end
                    end else begin
                        src_adr_reg <= src_adr_reg + 11'h001;
                        state_reg   <= ST_FETCH;
                    end
                end
                ST_DONE: state_reg <= ST_DONE;
                ST_FAIL: state_reg <= ST_FAIL;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_comb begin
        int_set = '0;
        int_set[INT_PROG]   = (state_reg == ST_STEP) && (src_adr_reg == SRC_LAST) && !verify_pass_reg;
        int_set[INT_VERIFY] = (state_reg == ST_STEP) && (src_adr_reg == SRC_LAST) && verify_pass_reg;
        int_set[INT_FAIL]   = (state_reg == ST_PROG) && verify_pass_reg && (rd_byte != src_s2_reg);
    end

    // A set in the same cycle as the clearing read wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= '0;
            int_mask_reg <= '0;
            irq          <= 1'b0;
        end else begin
            if (apb_rd && paddr == OFF_INT_STAT) begin
                int_stat_reg <= int_set;
            end else begin
                int_stat_reg <= int_stat_reg | int_set;
            end
            if (apb_wr && paddr == OFF_INT_MASK) begin
                int_mask_reg <= pwdata[INT_W-1:0];
            end
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h0000_0000;
                if (paddr == OFF_PCR) begin
                    prdata[7:0] <= PCR_UPPER | {5'h00, hv_sense_n, program_enable_n_reg, program_latch_n_reg};
                end else if (paddr == OFF_BOOT_CTRL) begin
                    prdata[0] <= 1'b0;
                end else if (paddr == OFF_BOOT_STAT) begin
                    prdata[15:0] <= {state_reg, 3'h0, boot_mode, 1'b0, verify_pass_reg, verified_led, programmed_led};
                end else if (paddr == OFF_INT_STAT) begin
                    prdata[INT_W-1:0] <= int_stat_reg;
                end else if (paddr == OFF_INT_MASK) begin
                    prdata[INT_W-1:0] <= int_mask_reg;
                end else if (paddr == OFF_EPROM_ADR) begin
                    prdata[10:0] <= eprom_adr_reg;
                end else if (paddr == OFF_EPROM_DAT) begin
                    prdata[7:0] <= program_latch_n_reg ? eprom_mem[eprom_adr_reg] : 8'h00;
                end else if (paddr == OFF_BOOT_VEC) begin
                    prdata[10:0] <= boot_mode ? BOOT_VEC_HI : RESET_VEC_HI;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    clear_before_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(counter_clear) |-> !counter_step) else $error("Step during clear.");
    clear_one_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
        counter_clear |=> !counter_clear) else $error("Clear longer than one cycle.");
    pge_needs_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        !program_enable_n_reg |-> !program_latch_n_reg) else $error("Enable low with latch high.");
    upper_ones_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && paddr == OFF_PCR && !pwrite) |-> prdata[7:3] == 5'h1f) else $error("Upper bits not ones.");
    verified_needs_prog_a: assert property (@(posedge pclk) disable iff (!presetn)
        verified_led |-> programmed_led) else $error("Verified before programmed.");
    fail_stops_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_FAIL |=> state_reg == ST_FAIL && !verified_led) else $error("Failure not held.");
    skip_nonuser_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == ST_FETCH && !in_user) |=> state_reg == ST_STEP) else $error("Non-user byte used.");
    step_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        counter_step |=> !counter_step) else $error("Step longer than one cycle.");
    verified_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(verified_led) |-> $past(verify_pass_reg)) else $error("Verified without verify pass.");
    strap_held_a: assert property (@(posedge pclk) disable iff (!presetn)
        rst_seen_reg |=> $stable(boot_mode)) else $error("Boot mode changed after start.");
    boot_start_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(counter_clear));
    boot_strap_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(boot_mode));
    prog_done_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(programmed_led));
    verify_done_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(verified_led));
    verify_fail_c: cover property (@(posedge pclk) disable iff (!presetn) state_reg == ST_FAIL);
endmodule

// file: rtl/epc_pkg.sv
// Purpose: Constants for the EPROM programming control and bootstrap copy block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Control register keeps three live bits; the upper five read as ones.
package epc_pkg;
    localparam int          ADDR_W        = 12;
    localparam int          SRC_W         = 11;
    localparam int          MEM_DEPTH     = 2048;
    localparam logic [11:0] IDX_PCR       = 12'h00b;
    localparam logic [11:0] OFF_PCR       = IDX_PCR << 2;
    localparam logic [11:0] OFF_BOOT_CTRL = 12'h040;
    localparam logic [11:0] OFF_BOOT_STAT = 12'h044;
    localparam logic [11:0] OFF_INT_STAT  = 12'h048;
    localparam logic [11:0] OFF_INT_MASK  = 12'h04c;
    localparam logic [11:0] OFF_EPROM_ADR = 12'h050;
    localparam logic [11:0] OFF_EPROM_DAT = 12'h054;
    localparam logic [11:0] OFF_BOOT_VEC  = 12'h058;
    localparam logic [7:0]  PCR_UPPER     = 8'hf8;
    localparam int          PCR_LATCH_B   = 0;
    localparam int          PCR_PGE_B     = 1;
    localparam int          PCR_HV_B      = 2;
    localparam int          BOOT_ROM_SIZE = 115;
    localparam logic [10:0] BOOT_VEC_HI   = 11'h7f6;
    localparam logic [10:0] BOOT_VEC_LO   = 11'h7f7;
    // Plain default for the normal reset vector.
    localparam logic [10:0] RESET_VEC_HI  = 11'h7fe;
    localparam logic [10:0] USER_LO       = 11'h080;
    localparam logic [10:0] USER_HI       = 11'h784;
    localparam logic [10:0] SRC_LAST      = 11'h7ff;
    // Kept short so that two full address walks stay well inside a practical run length.
    localparam int          PROG_NS       = 80;
    localparam int          CLK_NS        = 4;
    localparam int          PROG_CYC      = (PROG_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CNT_W         = 16;
    localparam int          INT_W         = 3;
    localparam int          INT_PROG      = 0;
    localparam int          INT_VERIFY    = 1;
    localparam int          INT_FAIL      = 2;
    typedef enum logic [7:0] {
        ST_IDLE   = 8'b0000_0001,
        ST_CLRH   = 8'b0000_0010,
        ST_CLRL   = 8'b0000_0100,
        ST_FETCH  = 8'b0000_1000,
        ST_PROG   = 8'b0001_0000,
        ST_STEP   = 8'b0010_0000,
        ST_DONE   = 8'b0100_0000,
        ST_FAIL   = 8'b1000_0000
    } epc_state_t;
endpackage

// file: test/epc_src_model.sv
// Purpose: External source EPROM behind an 11-bit binary counter.
// Assumes: Counter clear and step arrive as one-cycle pulses on pclk.
// Notes:   Byte pattern comes from the address so no array load is needed.
`timescale 1ns/10ps
module epc_src_model
    import epc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       counter_clear,
    input  wire logic       counter_step,
    output logic      [7:0] src_data,
    output logic      [7:0] clears,
    output logic            order_err
);
    logic [10:0] addr_reg;
    // The byte changes only on a step or a clear, so the design's synchroniser sees a stable value.
    assign src_data = addr_reg[7:0] ^ {5'h00, addr_reg[10:8]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg  <= 11'h000;
            clears    <= 8'h00;
            order_err <= 1'b0;
        end else begin
            if (counter_clear) begin
                addr_reg <= 11'h000;
                clears   <= clears + 8'h01;
            end else if (counter_step) begin
                addr_reg <= addr_reg + 11'h001;
                if (clears == 8'h00) order_err <= 1'b1;
            end
        end
    end
endmodule

// file: test/epc_top_tb.sv
// Purpose: Self-checking bench for the programming interlock and bootstrap sequencer.
// Assumes: APB slave answers with pready after the setup cycle.
// Notes:   One full copy-and-verify run takes about eighty-four thousand cycles.
`timescale 1ns/10ps
module epc_top_tb;
    import epc_pkg::*;
    typedef struct packed {logic [7:0] wd; logic vpp; logic [7:0] exp;} epc_row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        vpp_high = 1'b0;
    logic        strap = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        counter_clear;
    logic        counter_step;
    logic        programmed_led;
    logic        verified_led;
    logic        boot_mode;
    logic        irq;
    logic [7:0]  src_data;
    logic [7:0]  clears;
    logic        order_err;
    logic [31:0] rd;
    logic        err;
    int          fail_count = 0;
    int          samples_checked = 0;
    epc_row_t    rows [6] = '{
        '{8'h03, 1'b0, 8'hff}, '{8'h01, 1'b0, 8'hff}, '{8'h02, 1'b1, 8'hfa},
        '{8'h00, 1'b1, 8'hf8}, '{8'h07, 1'b1, 8'hfb}, '{8'h03, 1'b0, 8'hff}};
    epc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vpp_high(vpp_high), .timer_pin_program_level(strap), .src_data(src_data),
        .counter_clear(counter_clear), .counter_step(counter_step), .programmed_led(programmed_led),
        .verified_led(verified_led), .boot_mode(boot_mode), .irq(irq));
    epc_src_model src (.pclk(pclk), .presetn(presetn), .counter_clear(counter_clear),
        .counter_step(counter_step), .src_data(src_data), .clears(clears), .order_err(order_err));
    initial begin
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset(input logic s);
        @(posedge pclk);
        presetn <= 1'b0;
        strap   <= s;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (95000) @(posedge pclk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        do_reset(1'b0);
        chk({programmed_led, verified_led, boot_mode, irq, counter_clear}, 32'h0000_0000);
        apb(1'b0, OFF_PCR, 32'h0000_0000);
        chk({err, rd[7:0]}, {1'b0, 8'hff});
        apb(1'b0, OFF_BOOT_VEC, 32'h0000_0000);
        chk(rd[10:0], RESET_VEC_HI);
        // Each row writes the control byte and reads it back under a given supply level.
        // The sense bit is compared too, and must read low in each row with the supply raised.
        foreach (rows[i]) begin
            vpp_high <= rows[i].vpp;
            repeat (4) @(posedge pclk);
            apb(1'b1, OFF_PCR, {24'h00_0000, rows[i].wd});
            apb(1'b0, OFF_PCR, 32'h0000_0000);
            chk(rd[7:0], rows[i].exp);
        end
        apb(1'b0, 12'h100, 32'h0000_0000);
        chk(err, 1'b1);
        chk(clears, 8'h00);
        // Second reset with the strap at programming level runs the full bootstrap.
        vpp_high <= 1'b1;
        do_reset(1'b1);
        apb(1'b1, OFF_INT_MASK, 32'h0000_0001);
        chk(boot_mode, 1'b1);
        apb(1'b0, OFF_BOOT_VEC, 32'h0000_0000);
        chk(rd[10:0], BOOT_VEC_HI);
        while (programmed_led !== 1'b1) @(posedge pclk);
        chk(verified_led, 1'b0);
        chk(order_err, 1'b0);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b0, OFF_INT_STAT, 32'h0000_0000);
        chk(rd[INT_PROG], 1'b1);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        while (verified_led !== 1'b1) @(posedge pclk);
        apb(1'b0, OFF_INT_STAT, 32'h0000_0000);
        chk(rd[INT_W-1:0], 3'h2);
        repeat (3) @(posedge pclk);
        chk({clears, programmed_led, verified_led, irq}, {8'h02, 1'b1, 1'b1, 1'b0});
        tally_and_finish();
    end
endmodule
